// File: design/dstcr_pkg.sv
package dstcr_pkg;
  localparam int DIV_W  = 15;
  localparam int BAND_W = 4;
  // two-wire framing
  localparam logic [3:0] I2C_BYTE_DONE = 4'h8;
  localparam logic [3:0] I2C_ACK_DONE  = 4'h9;
  localparam logic [4:0] ADDR_FIXED    = 5'h18;
  localparam logic [1:0] ADDR_GENERAL  = 2'h1;
  localparam int         ADDR_MA_HI    = 2;
  localparam int         ADDR_MA_LO    = 1;
  localparam int         ADDR_RW       = 0;
  localparam int         BYTE_MSB      = 7;
  // three-wire word lengths and load points
  localparam logic [4:0] TW_BAND_CNT = 5'h04;
  localparam logic [4:0] TW_LEN_18   = 5'h12;
  localparam logic [4:0] TW_LEN_19   = 5'h13;
  localparam logic [4:0] TW_LEN_27   = 5'h1B;
  localparam logic [4:0] TW_CNT_MAX  = 5'h1F;
  localparam int         TW_SH_W     = 27;
  // reference divider ratios
  localparam logic [10:0] REF_DIV_640  = 11'h280;
  localparam logic [10:0] REF_DIV_1024 = 11'h400;
  localparam logic [10:0] REF_DIV_512  = 11'h200;
  // test patterns, msb first
  localparam logic [2:0] TEST_NORMAL   = 3'h1;
  localparam logic [2:0] TEST_SINK     = 3'h6;
  localparam logic [2:0] TEST_SOURCE   = 3'h7;
  localparam logic [2:0] TEST_LOCK_REF = 3'h4;
  localparam logic [2:0] TEST_LOCK_DIV = 3'h5;
  localparam int         TEST_OFF_BIT  = 1;

  typedef struct packed {
    logic       pump_current_select;
    logic       test_select_2;
    logic       test_select_1;
    logic       test_select_0;
    logic       ratio_select_a;
    logic       ratio_select_b;
    logic       tuning_output_off;
  } dstcr_ctrl_s;

  typedef struct packed {
    logic pump_off;
    logic pump_sink;
    logic pump_source;
    logic lock_shows_ref;
    logic lock_shows_half_div;
  } dstcr_test_s;

  typedef enum logic [1:0] {
    I2C_IDLE   = 2'b00,
    I2C_ADDR   = 2'b01,
    I2C_DATA   = 2'b10,
    I2C_IGNORE = 2'b11
  } dstcr_i2c_e;

  typedef enum logic [1:0] {
    KIND_DIV_HI = 2'b00,
    KIND_DIV_LO = 2'b01,
    KIND_CTRL   = 2'b10,
    KIND_BAND   = 2'b11
  } dstcr_kind_e;
endpackage

// File: design/dstcr_rx.sv
`timescale 1ns/1ps
// Contract
// - format select high three-wire, low two-wire
// - module address bits match address select
// - data bytes auto-increment after one address
// - first data msb picks frequency or control
// - data bytes accepted until stop
// - registers load after eighth clock of byte
// - divider is high seven plus low eight
// - pump current bit zero low, one high
// - test pattern 001 is normal operation
// - tuning off bit disables tuning output
// - band bits drive buffers, upper ignored
// - three-wire shifts on falling clock edge
// - band bits load on fifth rising edge
// - 18/19-bit frequency loads at enable fall
// - power-on control defaults applied
// - 18-bit word clears top bit, sets A
// - 19-bit word clears ratio select A
// - 27-bit frequency at 20th rise, control later
// - 27-bit uses both ratio select bits
// - three-wire control bits other than ratio select A change only by 27-bit
// - ratio bits select 640, 1024 or 512
// - test patterns select pump and lock tests
// - short three-wire word keeps frequency
module dstcr_rx
  import dstcr_pkg::*;
#(
  parameter logic RATIO_B_POR = 1'b1
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // serial pins
  input  wire logic        bus_format_select,
  input  wire logic [1:0]  addr_select_input,
  input  wire logic        ce_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // programmed state
  output logic [DIV_W-1:0] divider_ratio_bits,
  output dstcr_ctrl_s      pll_control,
  output logic             band_out_1,
  output logic             band_out_2,
  output logic             band_out_3,
  output logic             band_out_4,
  // decoded control
  output logic [10:0]      ref_divider,
  output dstcr_test_s      test_mode,
  output logic             tuning_output_enable
);

  localparam dstcr_ctrl_s CTRL_POR = '{
    pump_current_select: 1'b1,
    test_select_2:       TEST_NORMAL[2],
    test_select_1:       TEST_NORMAL[1],
    test_select_0:       TEST_NORMAL[0],
    ratio_select_a:      1'b0,
    ratio_select_b:      RATIO_B_POR,
    tuning_output_off:   1'b1
  };

  logic                scl_q_reg;
  logic                sda_q_reg;
  logic                ce_q_reg;
  dstcr_i2c_e          i2c_state_reg;
  logic [3:0]          i2c_bits_reg;
  logic [7:0]          i2c_sh_reg;
  logic [6:0]          div_hi_hold_reg;
  logic                pair_first_reg;
  dstcr_kind_e         next_kind_reg;
  logic                sda_oe_reg;
  logic                sda_out_reg;
  logic [4:0]          tw_cnt_reg;
  logic [TW_SH_W-1:0]  tw_sh_reg;
  logic [DIV_W-1:0]    divider_reg;
  dstcr_ctrl_s         ctrl_reg;
  logic [BAND_W-1:0]   band_reg;
  logic [10:0]         ref_div_reg;
  dstcr_test_s         test_reg;
  logic                tune_en_reg;

  logic        i2c_mode;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic        byte_done;
  logic        addr_match;
  logic        data_byte;
  dstcr_kind_e kind_now;
  logic        tw_active;
  logic        tw_band;
  logic        tw_rise20;
  logic        tw_end;
  logic [2:0]  test_bits;

  assign i2c_mode   = ~bus_format_select;
  assign scl_rise   = scl_in & ~scl_q_reg;
  assign scl_fall   = ~scl_in & scl_q_reg;
  assign start_cond = i2c_mode & scl_in & scl_q_reg & sda_q_reg & ~sda_in;
  assign stop_cond  = i2c_mode & scl_in & scl_q_reg & ~sda_q_reg & sda_in;
  assign byte_done  = i2c_mode & scl_fall & (i2c_bits_reg == I2C_BYTE_DONE);
  // general address answers writes whatever the address select
  assign addr_match = (i2c_sh_reg[7:3] == ADDR_FIXED)
                    & ~i2c_sh_reg[ADDR_RW]
                    & (({i2c_sh_reg[ADDR_MA_HI], i2c_sh_reg[ADDR_MA_LO]}
                        == addr_select_input)
                     | ({i2c_sh_reg[ADDR_MA_HI], i2c_sh_reg[ADDR_MA_LO]}
                        == ADDR_GENERAL));
  assign data_byte  = byte_done & (i2c_state_reg == I2C_DATA);
  assign tw_active  = ~i2c_mode & ce_in;
  assign tw_band    = tw_active & scl_rise & (tw_cnt_reg == TW_BAND_CNT);
  assign tw_rise20  = tw_active & scl_rise & (tw_cnt_reg == TW_LEN_19);
  assign tw_end     = ~i2c_mode & ce_q_reg & ~ce_in;
  assign test_bits  = {ctrl_reg.test_select_2, ctrl_reg.test_select_1,
                       ctrl_reg.test_select_0};

  // each pair of bytes opens with a kind chosen by its msb
  always_comb begin
    if (pair_first_reg) begin
      kind_now = i2c_sh_reg[BYTE_MSB] ? KIND_CTRL : KIND_DIV_HI;
    end else begin
      kind_now = next_kind_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      ce_q_reg  <= 1'b0;
    end else begin
      scl_q_reg <= scl_in;
      sda_q_reg <= sda_in;
      ce_q_reg  <= ce_in;
    end
  end

  // two-wire framing
  always_ff @(posedge clock) begin
    if (rst || !i2c_mode) begin
      i2c_state_reg  <= I2C_IDLE;
      i2c_bits_reg   <= 4'h0;
      i2c_sh_reg     <= 8'h00;
      pair_first_reg <= 1'b1;
      next_kind_reg  <= KIND_DIV_HI;
    end else if (start_cond) begin
      i2c_state_reg  <= I2C_ADDR;
      i2c_bits_reg   <= 4'h0;
      pair_first_reg <= 1'b1;
    end else if (stop_cond) begin
      i2c_state_reg  <= I2C_IDLE;
      i2c_bits_reg   <= 4'h0;
    end else if (i2c_state_reg != I2C_IDLE) begin
      if (scl_rise && i2c_bits_reg < I2C_BYTE_DONE) begin
        i2c_sh_reg   <= {i2c_sh_reg[6:0], sda_in};
        i2c_bits_reg <= i2c_bits_reg + 4'h1;
      end else if (scl_fall && i2c_bits_reg == I2C_ACK_DONE) begin
        i2c_bits_reg <= 4'h0;
      end else if (byte_done) begin
        i2c_bits_reg <= I2C_ACK_DONE;
        if (i2c_state_reg == I2C_ADDR) begin
          i2c_state_reg <= addr_match ? I2C_DATA : I2C_IGNORE;
        end else if (i2c_state_reg == I2C_DATA) begin
          // auto-increment to the partner byte of the pair
          pair_first_reg <= ~pair_first_reg;
          if (kind_now == KIND_DIV_HI) begin
            next_kind_reg <= KIND_DIV_LO;
          end else begin
            next_kind_reg <= KIND_BAND;
          end
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      div_hi_hold_reg <= 7'h00;
    end else if (data_byte && kind_now == KIND_DIV_HI) begin
      div_hi_hold_reg <= i2c_sh_reg[6:0];
    end
  end

  // acknowledge by holding data low through the ninth clock
  always_ff @(posedge clock) begin
    sda_out_reg <= 1'b0;
    if (rst || !i2c_mode || start_cond || stop_cond) begin
      sda_oe_reg <= 1'b0;
    end else if (byte_done) begin
      sda_oe_reg <= (i2c_state_reg == I2C_DATA)
                  | ((i2c_state_reg == I2C_ADDR) & addr_match);
    end else if (scl_fall && i2c_bits_reg == I2C_ACK_DONE) begin
      sda_oe_reg <= 1'b0;
    end
  end

  // three-wire shifter and falling-edge counter
  always_ff @(posedge clock) begin
    if (rst || i2c_mode) begin
      tw_cnt_reg <= 5'h00;
      tw_sh_reg  <= '0;
    end else if (tw_active && scl_fall) begin
      tw_sh_reg <= {tw_sh_reg[TW_SH_W-2:0], sda_in};
      if (tw_cnt_reg != TW_CNT_MAX) begin
        tw_cnt_reg <= tw_cnt_reg + 5'h01;
      end
    end else if (tw_end) begin
      tw_cnt_reg <= 5'h00;
    end
  end

  // frequency register
  always_ff @(posedge clock) begin
    if (rst) begin
      divider_reg <= '0;
    end else if (data_byte && kind_now == KIND_DIV_LO) begin
      divider_reg <= {div_hi_hold_reg, i2c_sh_reg};
    end else if (tw_rise20) begin
      divider_reg <= tw_sh_reg[DIV_W-1:0];
    end else if (tw_end && tw_cnt_reg == TW_LEN_18) begin
      divider_reg <= {1'b0, tw_sh_reg[DIV_W-2:0]};
    end else if (tw_end && tw_cnt_reg == TW_LEN_19) begin
      divider_reg <= tw_sh_reg[DIV_W-1:0];
    end
  end

  // control register; short words leave the frequency alone
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg <= CTRL_POR;
    end else if (data_byte && kind_now == KIND_CTRL) begin
      ctrl_reg <= dstcr_ctrl_s'(i2c_sh_reg[6:0]);
    end else if (tw_end && tw_cnt_reg == TW_LEN_27) begin
      ctrl_reg <= dstcr_ctrl_s'(tw_sh_reg[6:0]);
    end else if (tw_end && tw_cnt_reg == TW_LEN_18) begin
      ctrl_reg.ratio_select_a <= 1'b1;
    end else if (tw_end && tw_cnt_reg == TW_LEN_19) begin
      ctrl_reg.ratio_select_a <= 1'b0;
    end
  end

  // band switch register, upper nibble dropped
  always_ff @(posedge clock) begin
    if (rst) begin
      band_reg <= '0;
    end else if (data_byte && kind_now == KIND_BAND) begin
      band_reg <= i2c_sh_reg[BAND_W-1:0];
    end else if (tw_band) begin
      band_reg <= tw_sh_reg[BAND_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ref_div_reg <= REF_DIV_640;
    end else if (!ctrl_reg.ratio_select_b) begin
      ref_div_reg <= REF_DIV_640;
    end else if (ctrl_reg.ratio_select_a) begin
      ref_div_reg <= REF_DIV_512;
    end else begin
      ref_div_reg <= REF_DIV_1024;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      test_reg    <= '0;
      tune_en_reg <= 1'b0;
    end else begin
      test_reg.pump_off    <= ~test_bits[2] & test_bits[TEST_OFF_BIT];
      test_reg.pump_sink   <= (test_bits == TEST_SINK);
      test_reg.pump_source <= (test_bits == TEST_SOURCE);
      test_reg.lock_shows_ref      <= (test_bits == TEST_LOCK_REF);
      test_reg.lock_shows_half_div <= (test_bits == TEST_LOCK_DIV);
      tune_en_reg <= ~ctrl_reg.tuning_output_off;
    end
  end

  assign sda_out              = sda_out_reg;
  assign sda_oe               = sda_oe_reg;
  assign divider_ratio_bits   = divider_reg;
  assign pll_control          = ctrl_reg;
  assign band_out_1           = band_reg[0];
  assign band_out_2           = band_reg[1];
  assign band_out_3           = band_reg[2];
  assign band_out_4           = band_reg[3];
  assign ref_divider          = ref_div_reg;
  assign test_mode            = test_reg;
  assign tuning_output_enable = tune_en_reg;

  default clocking clk_dflt @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_low_byte;
    data_byte && kind_now == KIND_DIV_LO;
  endsequence
  sequence s_word_end(logic [4:0] len);
    tw_end && tw_cnt_reg == len;
  endsequence
  property p_three_wire_quiet;
    bus_format_select |=> !sda_oe_reg;
  endproperty
  a_three_wire_quiet: assert property (p_three_wire_quiet)
    else $error("data line driven in three-wire mode");
  property p_divider_join;
    s_low_byte |=> divider_reg ==
      {$past(div_hi_hold_reg), $past(i2c_sh_reg)};
  endproperty
  a_divider_join: assert property (p_divider_join)
    else $error("divider not assembled from the byte pair");
  property p_ack_hold;
    data_byte |=> sda_oe_reg [*2];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("data byte not acknowledged");
  property p_addr_refuse;
    byte_done && i2c_state_reg == I2C_ADDR && !addr_match |=> !sda_oe_reg;
  endproperty
  a_addr_refuse: assert property (p_addr_refuse)
    else $error("foreign address acknowledged");
  property p_band_fifth;
    tw_band |=> band_reg == $past(tw_sh_reg[BAND_W-1:0]);
  endproperty
  a_band_fifth: assert property (p_band_fifth)
    else $error("band bits not loaded on fifth rise");

  property p_word_18;
    s_word_end(TW_LEN_18) |=> !divider_reg[DIV_W-1]
      && ctrl_reg.ratio_select_a
      && ctrl_reg.pump_current_select == $past(ctrl_reg.pump_current_select);
  endproperty
  a_word_18: assert property (p_word_18)
    else $error("18-bit word handled wrongly");

  property p_word_19;
    s_word_end(TW_LEN_19) |=> !ctrl_reg.ratio_select_a
      && ctrl_reg.tuning_output_off == $past(ctrl_reg.tuning_output_off);
  endproperty
  a_word_19: assert property (p_word_19)
    else $error("19-bit word handled wrongly");

  property p_short_word;
    tw_end && tw_cnt_reg < TW_LEN_18 |=> $stable(divider_reg);
  endproperty
  a_short_word: assert property (p_short_word)
    else $error("short word changed the divider");

  property p_ref_640;
    !ctrl_reg.ratio_select_b |=> ref_div_reg == REF_DIV_640;
  endproperty
  a_ref_640: assert property (p_ref_640)
    else $error("reference divider not 640");

  property p_por;
    $fell(rst) |-> ctrl_reg == CTRL_POR && !tune_en_reg;
  endproperty
  a_por: assert property (p_por)
    else $error("power-on control defaults wrong");

endmodule

// File: verif/dstcr_host.sv
`timescale 1ns/1ps
module dstcr_host (
  // clock
  input  wire logic clock,
  // device data pin
  input  wire logic sda_out,
  input  wire logic sda_oe,
  // serial pins toward the device
  output logic      scl_in,
  output logic      sda_in,
  output logic      ce_in
);
  logic sda_drv;

  // open-drain data line with pull-up
  assign sda_in = sda_drv & ~(sda_oe & ~sda_out);

  initial begin
    sda_drv = 1'b1;
    scl_in  = 1'b1;
    ce_in   = 1'b0;
  end

  // every pin level lasts two system clocks
  task automatic step(input logic c, input logic d);
    scl_in  <= c;
    sda_drv <= d;
    repeat (2) @(posedge clock);
  endtask

  // data changes only while the clock is low
  task automatic bit_out(input logic d);
    step(1'b0, d);
    step(1'b1, d);
    step(1'b0, d);
  endtask

  // one start, n bytes msb first from the top of b, one stop
  task automatic i2c_xfer(input logic [39:0] b, input int n,
                          output int acks);
    acks = 0;
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      for (int j = 7; j >= 0; j--) begin
        bit_out(b[32-8*i+j]);
      end
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      acks += int'(!sda_in);
      step(1'b0, 1'b1);
    end
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask

  // clock is low before enable rises; bits go out msb first
  task automatic tw_word(input int n, input logic [26:0] w);
    step(1'b0, 1'b0);
    ce_in <= 1'b1;
    step(1'b0, 1'b0);
    for (int i = n - 1; i >= 0; i--) begin
      bit_out(w[i]);
    end
    ce_in <= 1'b0;
    step(1'b0, 1'b0);
  endtask
endmodule

// File: verif/tb_dstcr_rx.sv
`timescale 1ns/1ps
module tb_dstcr_rx;
  import dstcr_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] div;
    dstcr_ctrl_s      ctrl;
    logic [3:0]       band;
  } dstcr_note_s;

  logic             clock;
  logic             rst;
  logic             fmt;
  logic [1:0]       asel;
  logic             scl;
  logic             sda;
  logic             ce;
  logic             sda_out;
  logic             sda_oe;
  logic [DIV_W-1:0] div;
  dstcr_ctrl_s      ctrl;
  logic [3:0]       band;
  logic [10:0]      refd;
  dstcr_test_s      tmode;
  logic             tenb;
  dstcr_note_s      notes[$];
  dstcr_note_s      cur;
  int               mismatches;
  int               n_compared;
  event             chk;

  dstcr_rx i_dut (
    .clock(clock), .rst(rst), .bus_format_select(fmt),
    .addr_select_input(asel), .ce_in(ce), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .divider_ratio_bits(div),
    .pll_control(ctrl), .band_out_1(band[0]), .band_out_2(band[1]),
    .band_out_3(band[2]), .band_out_4(band[3]), .ref_divider(refd),
    .test_mode(tmode), .tuning_output_enable(tenb)
  );

  dstcr_host i_host (
    .clock(clock), .sda_out(sda_out), .sda_oe(sda_oe),
    .scl_in(scl), .sda_in(sda), .ce_in(ce)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic check(input string nm, input logic [14:0] seen,
                       input logic [14:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic note();
    notes.push_back(cur);
    ->chk;
  endtask

  // monitor: compares settled outputs against the oldest note
  initial begin
    dstcr_note_s e;
    logic [2:0]  t;
    logic [10:0] rd;
    forever begin
      @(chk);
      repeat (3) @(posedge clock);
      e = notes.pop_front();
      t = {e.ctrl.test_select_2, e.ctrl.test_select_1,
           e.ctrl.test_select_0};
      rd = !e.ctrl.ratio_select_b ? REF_DIV_640 :
           e.ctrl.ratio_select_a ? REF_DIV_512 : REF_DIV_1024;
      check("divider", div, e.div);
      check("control", 15'(ctrl), 15'(e.ctrl));
      check("band", 15'(band), 15'(e.band));
      check("ref_div", 15'(refd), 15'(rd));
      check("test", 15'(tmode), {10'h0, t[2:1] == 2'b01, t == TEST_SINK,
            t == TEST_SOURCE, t == TEST_LOCK_REF, t == TEST_LOCK_DIV});
      check("tune_en", 15'(tenb), 15'(!e.ctrl.tuning_output_off));
    end
  end

  initial begin
    repeat (30000) @(posedge clock);
    mismatches++;
    $display("watchdog expired");
    test_done();
  end

  initial begin
    logic [14:0] d;
    logic [7:0]  ctl_byte;
    logic [7:0]  band_byte;
    logic [6:0]  c;
    int          a;
    rst = 1'b1;
    fmt = 1'b0;
    asel = 2'b10;
    a = $urandom(32'h2674A5D3);
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    cur = '{15'h0000, 7'h4B, 4'h0};
    note();
    $display("test power_on done");
    d = 15'($urandom);
    ctl_byte = {1'b1, 7'($urandom)};
    band_byte = 8'($urandom);
    i_host.i2c_xfer({8'hC4, 1'b0, d[14:8], d[7:0], ctl_byte, band_byte}, 5,
                    a);
    check("acks", 15'(a), 15'h0005);
    cur = '{d, ctl_byte[6:0], band_byte[3:0]};
    note();
    $display("test i2c_full done");
    ctl_byte = {1'b1, 7'($urandom)};
    band_byte = 8'($urandom);
    i_host.i2c_xfer({8'hC2, ctl_byte, band_byte, 8'h15, 8'h00}, 4, a);
    check("acks", 15'(a), 15'h0004);
    cur.ctrl = ctl_byte[6:0];
    cur.band = band_byte[3:0];
    note();
    $display("test i2c_partial done");
    asel <= 2'b11;
    i_host.i2c_xfer({8'hC4, 8'h01, 8'h02, 8'h80, 8'h0F}, 5, a);
    check("acks", 15'(a), 15'h0000);
    note();
    $display("test i2c_wrong_addr done");
    // matching module bits but a read request must be refused
    asel <= 2'b00;
    i_host.i2c_xfer({8'hC1, 8'h7F, 24'h000000}, 2, a);
    check("acks", 15'(a), 15'h0000);
    d = 15'($urandom);
    i_host.i2c_xfer({8'hC0, 1'b0, d[14:8], d[7:0], 16'h0000}, 3, a);
    check("acks", 15'(a), 15'h0003);
    cur.div = d;
    note();
    $display("test i2c_addr_zero done");
    fmt <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      d = 15'($urandom);
      band_byte = 8'($urandom);
      c = {1'($urandom), 3'(k), 3'($urandom)};
      i_host.tw_word(27, {band_byte[3:0], d, 1'b1, c});
      cur = '{d, c, band_byte[3:0]};
      note();
    end
    $display("test tw_27 done");
    d = 15'($urandom);
    band_byte = 8'($urandom);
    i_host.tw_word(18, {9'h000, band_byte[3:0], d[13:0]});
    cur = '{{1'b0, d[13:0]}, cur.ctrl, band_byte[3:0]};
    cur.ctrl.ratio_select_a = 1'b1;
    note();
    i_host.tw_word(19, {8'h00, band_byte[7:4], d});
    cur = '{d, cur.ctrl, band_byte[7:4]};
    cur.ctrl.ratio_select_a = 1'b0;
    note();
    $display("test tw_18_19 done");
    band_byte = 8'($urandom);
    i_host.tw_word(10, {17'h00000, band_byte[3:0], 6'h2A});
    cur.band = band_byte[3:0];
    note();
    $display("test tw_short done");
    repeat (10) @(posedge clock);
    test_done();
  end
endmodule
